// ### subaudible_tone_code_select.v
`timescale 1ns/10ps
`default_nettype none
`include "tone_sel_consts.vh"

module subaudible_tone_code_select
#(
  parameter DEC_LIMIT_CYC = `DEC_LIMIT_CYC,
  parameter HW            = 20
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire [5:0]  tone_select_bits,
  input  wire        rx_tx_select,
  input  wire        listen_override_phase_flip,
  input  wire        latch_strobe,
  input  wire        tone_in,
  output wire        tone_out,
  output reg         tone_out_en,
  output reg         rx_tone_detect,
  output reg         tone_decode_n,
  output reg         rx_audio_enable,
  output reg         tx_audio_enable
);

  // ----------------------------------------------------------------
  // Tone table
  // ----------------------------------------------------------------
  // Code is {bit5..bit0}; zero half period means no tone
  function [HW-1:0] half_of;
    input [5:0] c;
    reg   [63:0] h;
    begin
      h = 64'd0;
      case (c)
        6'd63: h = `HALF_CYC(64'd6705);
        6'd31: h = `HALF_CYC(64'd7190);
        6'd62: h = `HALF_CYC(64'd7435);
        6'd15: h = `HALF_CYC(64'd7696);
        6'd61: h = `HALF_CYC(64'd7977);
        6'd30: h = `HALF_CYC(64'd8259);
        6'd60: h = `HALF_CYC(64'd8538);
        6'd14: h = `HALF_CYC(64'd8861);
        6'd59: h = `HALF_CYC(64'd9158);
        6'd29: h = `HALF_CYC(64'd9476);
        6'd58: h = `HALF_CYC(64'd9729);
        6'd13: h = `HALF_CYC(64'd9996);
        6'd28: h = `HALF_CYC(64'd10343);
        6'd12: h = `HALF_CYC(64'd10715);
        6'd27: h = `HALF_CYC(64'd11077);
        6'd11: h = `HALF_CYC(64'd11464);
        6'd26: h = `HALF_CYC(64'd11880);
        6'd10: h = `HALF_CYC(64'd12280);
        6'd25: h = `HALF_CYC(64'd12708);
        6'd9:  h = `HALF_CYC(64'd13167);
        6'd24: h = `HALF_CYC(64'd13661);
        6'd8:  h = `HALF_CYC(64'd14132);
        6'd23: h = `HALF_CYC(64'd14637);
        6'd7:  h = `HALF_CYC(64'd15109);
        6'd22: h = `HALF_CYC(64'd15688);
        6'd6:  h = `HALF_CYC(64'd16231);
        6'd21: h = `HALF_CYC(64'd16814);
        6'd5:  h = `HALF_CYC(64'd17348);
        6'd20: h = `HALF_CYC(64'd18015);
        6'd4:  h = `HALF_CYC(64'd18629);
        6'd19: h = `HALF_CYC(64'd19286);
        6'd3:  h = `HALF_CYC(64'd20365);
        6'd18: h = `HALF_CYC(64'd21017);
        6'd2:  h = `HALF_CYC(64'd21858);
        6'd17: h = `HALF_CYC(64'd22612);
        6'd1:  h = `HALF_CYC(64'd23419);
        6'd16: h = `HALF_CYC(64'd24108);
        6'd0:  h = `HALF_CYC(64'd25028);
        default: h = 64'd0;
      endcase
      half_of = h[HW-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [9:0] pins_s;   // Synchronised strobe, tone, listen, rx_tx, bits
  reg  [9:0] pins_d;   // One cycle delayed copy for edges

  sync_stage #(.WIDTH(10)) u_sync (
    .clk     (hclk),
    .rst_n   (hresetn),
    .ce      (ce),
    .d       ({latch_strobe, tone_in, listen_override_phase_flip,
               rx_tx_select, tone_select_bits}),
    .rst_val (10'h3ff),
    .q       (pins_s)
  );

  wire [5:0] bits_s          = pins_s[5:0];
  wire       serial_clock_pin = pins_s[2];
  wire       serial_data_pin  = pins_s[3];
  wire       mode_select_low  = pins_s[4];
  wire       mode_select_high = pins_s[5];
  wire       strobe_s        = pins_s[9];
  wire       tone_s          = pins_s[8];

  wire serial_mode = ~mode_select_low & mode_select_high;

  wire sclk_rise   = serial_clock_pin & ~pins_d[2];
  wire strobe_fall = ~strobe_s & pins_d[9];
  wire tone_rise   = tone_s & ~pins_d[8];

  // ----------------------------------------------------------------
  // Serial shift and holding latches
  // ----------------------------------------------------------------
  reg [7:0] shift_word; // Bits as shifted, bit5 ends at top
  reg [7:0] hold;       // The eight holding latches

  // Shifted order maps to word: tone bits, then rx/tx, then listen
  wire [7:0] shift_as_word = {shift_word[0], shift_word[1],
                              shift_word[7:2]};

  // Holding latch control
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pins_d     <= 10'h3ff;
      shift_word <= `WORD_RST;
      hold       <= `WORD_RST;
    end
    else if (ce)
    begin
      pins_d <= pins_s;
      if (serial_mode)
      begin
        if (sclk_rise)
          shift_word <= {shift_word[6:0], serial_data_pin};
        if (strobe_fall)
          hold <= shift_as_word;
      end
      else if (strobe_s)
      begin
        hold <= {pins_s[7], pins_s[6], bits_s};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  reg       sw_sel;   // Software word replaces the latches
  reg [7:0] prog;     // Software programmed word
  reg       wr_pend;  // Write data phase pending
  reg [5:0] wr_idx;   // Register index of pending write

  wire addr_ok = (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'b00);
  wire take    = hsel & hready & htrans[1];

  // Always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Word that drives the whole block
  wire [7:0] word    = sw_sel ? prog : hold;
  wire [5:0] code    = word[`F_TONE_HI:0];
  wire       rx_mode = word[`F_RX_TX];
  wire       listen_flip = word[`F_LISTEN];

  reg detect; // Decoder result

  // Registers and read data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_sel  <= `CTRL_RST;
      prog    <= `PROG_RST;
      wr_pend <= 1'b0;
      wr_idx  <= 6'h00;
      hrdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      // Data phase of an earlier write
      if (wr_pend)
      begin
        case (wr_idx)
          `REG_CTRL: sw_sel <= hwdata[`CTRL_SW_SEL];
          `REG_PROG: prog   <= hwdata[7:0];
          default:   prog   <= prog;
        endcase
      end
      wr_pend <= take & hwrite & addr_ok;
      wr_idx  <= haddr[7:2];
      // Read data set up during the address phase
      if (take & ~hwrite & addr_ok)
      begin
        case (haddr[7:2])
          `REG_CTRL: hrdata <= {31'h0000_0000, sw_sel};
          `REG_PROG: hrdata <= {24'h00_0000, prog};
          `REG_STAT: hrdata <= {20'h0_0000, (half_of(code) != 0),
                                (code == `CODE_NOTONE), serial_mode,
                                detect, word};
          default:   hrdata <= 32'h0000_0000;
        endcase
      end
      else if (take)
      begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tone selection and encoder
  // ----------------------------------------------------------------
  wire [HW-1:0] half   = half_of(code);
  wire          notone = (code == `CODE_NOTONE);
  wire          has_tone = (half != {HW{1'b0}});

  tone_divider #(.CW(HW)) u_gen (
    .clk    (hclk),
    .rst_n  (hresetn),
    .ce     (ce),
    .run    (has_tone & ~rx_mode),
    .half   (half),
    .invert (listen_flip),
    .tone   (tone_out)
  );

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  reg  [HW:0] per_cnt;   // Cycles since last rising tone edge
  reg  [3:0]  good_cnt;  // Matching periods in a row
  reg  [3:0]  bad_cnt;   // Mismatching periods in a row

  wire [HW:0] period = {half, 1'b0};
  wire [HW:0] tol    = {5'h00, period[HW:5]};
  wire        in_win = (per_cnt >= period - tol) &
                       (per_cnt <= period + tol);
  // Silence timeout is two periods, never past the limit
  wire [63:0] two_per = {{(63-HW-1){1'b0}}, period, 1'b0};
  wire        silent  = ({{(63-HW){1'b0}}, per_cnt} >= two_per) |
                        ({{(63-HW){1'b0}}, per_cnt} >= DEC_LIMIT_CYC);
  wire        dec_en  = rx_mode & has_tone;

  // Period measure and detect state
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      per_cnt  <= {(HW+1){1'b0}};
      good_cnt <= 4'h0;
      bad_cnt  <= 4'h0;
      detect   <= 1'b0;
    end
    else if (ce)
    begin
      if (!dec_en)
      begin
        per_cnt  <= {(HW+1){1'b0}};
        good_cnt <= 4'h0;
        bad_cnt  <= 4'h0;
        detect   <= 1'b0;
      end
      else if (tone_rise)
      begin
        per_cnt <= {(HW+1){1'b0}};
        if (in_win)
        begin
          bad_cnt <= 4'h0;
          if (good_cnt != `DET_PERIODS)
            good_cnt <= good_cnt + 4'h1;
          if (good_cnt >= `DET_PERIODS - 4'h1)
            detect <= 1'b1;
        end
        else
        begin
          good_cnt <= 4'h0;
          if (bad_cnt != `REL_PERIODS)
            bad_cnt <= bad_cnt + 4'h1;
          if (bad_cnt >= `REL_PERIODS - 4'h1)
            detect <= 1'b0;
        end
      end
      else if (silent)
      begin
        good_cnt <= 4'h0;
        detect   <= 1'b0;
      end
      else
      begin
        per_cnt <= per_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Path control outputs
  // ----------------------------------------------------------------
  // Registered so the pins never glitch on a code change
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tone_out_en     <= 1'b0;
      rx_tone_detect  <= 1'b0;
      tone_decode_n   <= 1'b1;
      rx_audio_enable <= 1'b0;
      tx_audio_enable <= 1'b0;
    end
    else if (ce)
    begin
      tone_out_en     <= ~rx_mode & has_tone;
      rx_tone_detect  <= detect;
      tone_decode_n   <= ~(rx_mode & (detect | notone));
      rx_audio_enable <= rx_mode & (detect | listen_flip | notone);
      tx_audio_enable <= ~rx_mode;
    end
  end

  // Bus field hsize not used by a word-only slave, tied off together with haddr[7:2]
  wire unused_ok = &{1'b0, hsize, haddr[7:2]};

endmodule // subaudible_tone_code_select

`default_nettype wire

// ### sync_stage.v
`timescale 1ns/10ps
`default_nettype none

module sync_stage
#(
  parameter WIDTH = 1
)
(
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] d,
  input  wire [WIDTH-1:0] rst_val,
  output reg  [WIDTH-1:0] q
);

  // First stage, read only by the second stage
  reg [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // Two flop crossing
  // ----------------------------------------------------------------
  // Reset value is a constant all ones inside this module; the rst_val tie at the instance is not used
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= {WIDTH{1'b1}};
      q    <= {WIDTH{1'b1}};
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end

  // Unused reset value tap kept for width checks only
  wire unused_ok = &{1'b0, rst_val};

endmodule // sync_stage

`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic        tone_in;
  logic [31:0] rnd = 32'h0000_0028; // Xorshift state
  logic [31:0] seen_q[$];           // Observed results, oldest first
  logic [7:0]  cur;                 // Expected effective word
  logic [7:0]  sw;                  // Word sent serially
  logic [7:0]  w;
  int          n_fail;
  int          tests_run;
  event        got;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string       nm_q[$];
  wire         hreadyout, hresp, tone_out, tone_out_en, rx_tone_detect, tone_decode_n;
  wire         rx_audio_enable, tx_audio_enable, rx_tx_select, lpf, latch_strobe;
  wire [31:0]  hrdata;
  wire [5:0]   tone_select_bits;
  subaudible_tone_code_select #(.DEC_LIMIT_CYC(2000)) uut
  (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tone_select_bits(tone_select_bits), .rx_tx_select(rx_tx_select),
    .listen_override_phase_flip(lpf), .latch_strobe(latch_strobe), .tone_in(tone_in),
    .tone_out(tone_out), .tone_out_en(tone_out_en), .rx_tone_detect(rx_tone_detect),
    .tone_decode_n(tone_decode_n), .rx_audio_enable(rx_audio_enable),
    .tx_audio_enable(tx_audio_enable)
  );
  tone_host_model host
  (
    .hclk(hclk), .tone_select_bits(tone_select_bits), .rx_tx_select(rx_tx_select),
    .listen_override_phase_flip(lpf), .latch_strobe(latch_strobe)
  );
  // ------------------------------------------------
  // Clock, noise on the tone input
  // ------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Random bits never form a steady tone, so detect stays low
  always @(posedge hclk)
  begin
    rnd <= xs(rnd);
    tone_in <= rnd[0];
  end
  // ------------------------------------------------
  // Expectations and checking
  // ------------------------------------------------
  function automatic logic vld(input logic [5:0] c);
    return (c < 6'h20) || (c >= 6'h3a);
  endfunction
  function automatic logic [31:0] stat(input logic [7:0] v, input logic s);
    return {20'h0, vld(v[5:0]), v[5:0] == 6'h30, s, 1'b0, v};
  endfunction
  // Divider phase stays zero: the whole run is far shorter than any half period,
  // so the tone pin shows only the phase flip bit while sending
  function automatic logic [31:0] outs(input logic [7:0] v);
    logic nt;
    nt = (v[5:0] == 6'h30);
    return {26'h0, !v[6] && vld(v[5:0]) && v[7], !v[6] && vld(v[5:0]), !v[6],
            v[6] && (v[7] || nt), !(v[6] && nt), 1'b0};
  endfunction
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic note(input string nm, input logic [31:0] e, input logic [31:0] m);
    nm_q.push_back(nm);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
  endtask
  // Watcher pairs each result with the oldest note
  initial
  forever
  begin
    @(got);
    // Drain all: several results may be posted in one time step
    while (seen_q.size() > 0)
      check(nm_q.pop_front(), seen_q.pop_front() & msk_q.pop_front(), exp_q.pop_front());
  end
  // ------------------------------------------------
  // Bus master and scenarios
  // ------------------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] r;
    note(nm, e, m);
    note("hresp", 32'h0, 32'h1);
    bus(1'b0, a, 32'h0, r);
    seen_q.push_back(r);
    seen_q.push_back({31'h0, hresp});
    ->got;
  endtask
  task automatic chk_word(input logic [7:0] v, input logic s);
    rd("status", 32'h8, stat(v, s), 32'hfff);
    note("outputs", outs(v), 32'h3f);
    seen_q.push_back({26'h0, tone_out, tone_out_en, tx_audio_enable, rx_audio_enable,
                      tone_decode_n, rx_tone_detect});
    ->got;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    stop_test();
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, tone_in} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctrl", 32'h0, 32'h0, 32'h1);
    rd("prog", 32'h4, 32'hff, 32'hff);
    rd("unmapped", 32'h10, 32'h0, 32'hffff_ffff);
    rd("high", 32'h100, 32'h0, 32'hffff_ffff);
    wr(32'h8, 32'h0);
    chk_word(8'hff, 1'b0);
    sw = rnd[7:0];
    host.ser_shift({rnd[9], sw[5:0], sw[6], sw[7]}, 9);
    rd("shifted", 32'h8, stat(8'hff, 1'b1), 32'hfff);
    host.strobe_pulse();
    rd("loaded", 32'h8, stat(sw, 1'b1), 32'hfff);
    host.release_pins();
    repeat (6) @(posedge hclk);
    chk_word(sw, 1'b0);
    cur = sw;
    w = rnd[15:8];
    wr(32'h0, 32'h1);
    wr(32'h4, {24'h0, w});
    rd("prog", 32'h4, {24'h0, w}, 32'hff);
    rd("ctrl", 32'h0, 32'h1, 32'h1);
    chk_word(w, 1'b0);
    wr(32'h0, 32'h0);
    rd("status", 32'h8, stat(cur, 1'b0), 32'hfff);
    for (int c = 0; c < 64; c++)
    begin
      w = {rnd[1:0], c[5:0]};
      host.par_load(w);
      repeat (6) @(posedge hclk);
      // Serial entry codes refuse pass-through; the strobe loads the shifted word
      cur = (c[5:4] == 2'b10) ? sw : w;
      chk_word(cur, 1'b0);
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_word(8'hff, 1'b0);
    // Let the watcher drain the last results before the verdict
    repeat (2) @(posedge hclk);
    stop_test();
  end
endmodule // tb
bind subaudible_tone_code_select tone_sel_monitor mon
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .latch_strobe(latch_strobe),
  .rx_tx_select(rx_tx_select), .tone_select_bits(tone_select_bits), .tone_out(tone_out),
  .tone_out_en(tone_out_en), .rx_tone_detect(rx_tone_detect), .tone_decode_n(tone_decode_n),
  .rx_audio_enable(rx_audio_enable), .tx_audio_enable(tx_audio_enable)
);
`default_nettype wire

// ### tone_divider.v
`timescale 1ns/10ps
`default_nettype none

module tone_divider
#(
  parameter CW = 20
)
(
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ce,
  input  wire          run,
  input  wire [CW-1:0] half,
  input  wire          invert,
  output reg           tone
);

  reg [CW-1:0] cnt;   // Cycles into current half period
  reg          phase; // Raw square wave

  // ----------------------------------------------------------------
  // Half period divider
  // ----------------------------------------------------------------
  // Divides the system clock, so accuracy is that of the clock
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt   <= {CW{1'b0}};
      phase <= 1'b0;
      tone  <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        cnt   <= {CW{1'b0}};
        phase <= 1'b0;
      end
      else if (cnt >= half - 1'b1)
      begin
        cnt   <= {CW{1'b0}};
        phase <= ~phase;
      end
      else
      begin
        cnt <= cnt + 1'b1;
      end
      // Phase flip acts at once, for tail elimination
      tone <= run & (phase ^ invert);
    end
  end

endmodule // tone_divider

`default_nettype wire

// ### tone_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// Host driving the programming pins
// ------------------------------------------------
module tone_host_model
(
  input  wire logic       hclk,
  output wire logic [5:0] tone_select_bits,
  output logic            rx_tx_select,
  output logic            listen_override_phase_flip,
  output logic            latch_strobe
);
  logic [5:0] pv; // Parallel value, idles at the pull-up level
  logic       se; // Serial frame active
  logic       sc; // Serial clock, parked low inside frames
  logic       sd; // Serial data
  assign tone_select_bits = se ? {2'b10, sd, sc, pv[1:0]} : pv;
  initial
  begin
    pv = 6'h3f;
    se = 1'b0;
    sc = 1'b0;
    sd = 1'b1;
    rx_tx_select = 1'b1;
    listen_override_phase_flip = 1'b1;
    latch_strobe = 1'b0;
  end
  // Leave serial mode with the clock pin low, so no stray rise shifts
  task automatic release_pins();
    @(posedge hclk);
    pv <= 6'h3b;
    se <= 1'b0;
    @(posedge hclk);
    pv <= 6'h3f;
    rx_tx_select <= 1'b1;
    listen_override_phase_flip <= 1'b1;
  endtask
  task automatic strobe_pulse();
    @(posedge hclk);
    latch_strobe <= 1'b1;
    repeat (20) @(posedge hclk);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task automatic par_load(input logic [7:0] w);
    @(posedge hclk);
    pv <= w[5:0];
    rx_tx_select <= w[6];
    listen_override_phase_flip <= w[7];
    strobe_pulse();
    release_pins();
  endtask
  // first bit sent is the highest index, 8 cycle clock
  task automatic ser_shift(input logic [8:0] v, input int n);
    @(posedge hclk);
    se <= 1'b1;
    sc <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sd <= v[i];
      repeat (4) @(posedge hclk);
      sc <= 1'b1;
      repeat (4) @(posedge hclk);
      sc <= 1'b0;
    end
  endtask
endmodule // tone_host_model
`default_nettype wire

// ### tone_sel_consts.vh
`ifndef TONE_SEL_CONSTS_VH
`define TONE_SEL_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_HZ        64'd50000000
`define DEC_LIMIT_MS  64'd250
`define DEC_LIMIT_CYC ((`CLK_HZ / 64'd1000) * `DEC_LIMIT_MS)
`define DET_PERIODS   4'h8
`define REL_PERIODS   4'h4
// Half period in clock cycles from a tone in centihertz
`define HALF_CYC(ch)  ((`CLK_HZ * 64'd50) / (ch))

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL      6'h00
`define REG_PROG      6'h01
`define REG_STAT      6'h02

// ----------------------------------------------------------------
// Field positions of the programmed word and the control register
// ----------------------------------------------------------------
`define F_TONE_HI     5
`define F_RX_TX       6
`define F_LISTEN      7
`define CTRL_SW_SEL   0

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define CODE_NOTONE   6'h30
`define WORD_RST      8'hff
`define PROG_RST      8'hff
`define CTRL_RST      1'b0

`endif

// ### tone_sel_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// Port checker for the tone code select block
// ------------------------------------------------
module tone_sel_monitor
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic       latch_strobe,
  input wire logic       rx_tx_select,
  input wire logic [5:0] tone_select_bits,
  input wire logic       tone_out,
  input wire logic       tone_out_en,
  input wire logic       rx_tone_detect,
  input wire logic       tone_decode_n,
  input wire logic       rx_audio_enable,
  input wire logic       tx_audio_enable
);
  // Serial entry pattern on the mode pins
  wire ser = (tone_select_bits[5:4] == 2'b10);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Three cycles of slack, though the divider output is registered in the same cycle as the enable
  AST_IDLE_LOW: assert property (!tone_out_en [*3] |-> !tone_out)
    else $error("tone output not low while off");
  AST_TX_ONLY: assert property (tone_out_en |-> tx_audio_enable && !rx_audio_enable)
    else $error("tone sent outside transmit");
  AST_DECODE_AUDIO: assert property (!tone_decode_n |-> rx_audio_enable && !tx_audio_enable)
    else $error("decode flag without receive audio");
  AST_TX_NO_DET: assert property (tx_audio_enable |-> !rx_tone_detect && tone_decode_n)
    else $error("decoder active in transmit");
  // Synchroniser lag: tx_audio_enable holds one cycle after a strobe rise
  AST_SYNC_LAG: assert property ($rose(latch_strobe) && !hsel && !$past(hsel)
    |=> $stable(tx_audio_enable))
    else $error("strobe acted before synchronisation");
  AST_LATCH_HOLD: assert property ((!latch_strobe && !hsel) [*8] |-> $stable(tx_audio_enable))
    else $error("latched word moved while strobe low");
  AST_PASS_TX: assert property ((latch_strobe && !rx_tx_select && !ser && !hsel) [*6]
    |-> tx_audio_enable)
    else $error("transparent latch missed transmit select");
  AST_PASS_RX: assert property ((latch_strobe && rx_tx_select && !ser && !hsel) [*6]
    |-> !tx_audio_enable && !tone_out_en)
    else $error("transparent latch missed receive select");
  AST_SER_BLOCK: assert property ((latch_strobe && ser && !hsel) [*6] |-> $stable(tx_audio_enable))
    else $error("pass-through active in serial mode");
endmodule // tone_sel_monitor
`default_nettype wire
